// *** rtl/serial0_pkg.sv ***
// constants and types shared by the serial port 0 control/status block
// Summary of operation
// RULE1: mode bit 3 at 0 gives two wires; bit 2 at 0 serial, at 1 bus.
// RULE2: mode bit 1 at 0 makes the port master; bit 0 at 0 receive, 1 send.
// RULE3: in bus mode the ack bit sets the driven ack and reads the partner's.
// RULE4: wait permit at 0 allows a wait hold; writing 1 releases any wait.
// RULE5: count8/count9 flags set at count 8/9 and clear at count 0 or 1.
// RULE6: in bus mode the clock window flag is 1 from start to the 9th clock.
// RULE7: in bus mode the busy flag sets on a start and clears on a stop.
// RULE8: wait mode picks no wait, or wait after data, ack or the address.
// RULE9: the event fires at clock 7, clock 8, clock 7 after start, or stop.
// RULE10: clock select codes 0 to 3 give 100 kHz, 200 kHz, 500 kHz, 1 MHz.
package serial0_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MODE = 8'h08;
  localparam logic [7:0] IDX_WAIT = 8'h18;
  localparam logic [7:0] IDX_STATUS = 8'h28;
  localparam logic [7:0] IDX_EVENT = 8'h38;
  localparam logic [7:0] IDX_CLKSEL = 8'h39;
  localparam logic [7:0] IDX_XFER = 8'h3a;
  localparam int ADDR_SHIFT = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_LINES = 3;
  localparam int MODE_PROTO = 2;
  localparam int MODE_ROLE = 1;
  localparam int MODE_DIR = 0;
  localparam int WAIT_ACK = 3;
  localparam int WAIT_PERMIT = 2;
  localparam int XFER_GO = 0;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] WAIT_RESET = 4'h0;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // wait modes and event conditions
  // ----------------------------------------------------------------
  localparam logic [1:0] WMODE_NONE = 2'h0;
  localparam logic [1:0] WMODE_DATA = 2'h1;
  localparam logic [1:0] WMODE_ACK = 2'h2;
  localparam logic [1:0] WMODE_ADDR = 2'h3;
  localparam logic [1:0] EVT_CLK7 = 2'h0;
  localparam logic [1:0] EVT_CLK8 = 2'h1;
  localparam logic [1:0] EVT_START7 = 2'h2;
  localparam logic [1:0] EVT_STOP = 2'h3;

  // ----------------------------------------------------------------
  // clock counter marks
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_SEVEN = 4'h7;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_NINE = 4'h9;

  // ----------------------------------------------------------------
  // serial clock rates
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int RATE0_KHZ = 100;
  localparam int RATE1_KHZ = 200;
  localparam int RATE2_KHZ = 500;
  localparam int RATE3_KHZ = 1000;
  localparam int HALF_W = 9;

  function automatic logic [HALF_W-1:0] half_cycles(input logic [1:0] sel);
    int khz;
    khz = RATE0_KHZ;
    unique case (sel)
      2'h0: khz = RATE0_KHZ;
      2'h1: khz = RATE1_KHZ;
      2'h2: khz = RATE2_KHZ;
      2'h3: khz = RATE3_KHZ;
    endcase
    half_cycles = HALF_W'(REF_CLK_HZ / (2 * khz * 1000));
  endfunction

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_LOW = 2'b01,
    GEN_HIGH = 2'b10
  } gen_state_type;

endpackage

// *** rtl/sync3.sv ***
// three-stage synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst, // async reset, active high
  input wire logic [WIDTH-1:0] d, // foreign-domain level
  output logic [WIDTH-1:0] q // accepted level
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (s2_reg == s3_reg) begin
      q_next = s3_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// *** rtl/link_sampler.sv ***
// link-domain sampler of the data line
`timescale 1ns/1ps
module link_sampler (
  input wire logic link_clk, // serial clock as seen on the line
  input wire logic rst, // async reset, active high
  input wire logic sda_in, // data line level
  output logic bit_level // last bit sampled, held until next rise
);
  logic bit_reg;
  logic bit_next;

  // held between rises for the system side
  always_comb begin
    bit_next = sda_in;
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bit_reg <= 1'b0;
    end else begin
      bit_reg <= bit_next;
    end
  end

  assign bit_level = bit_reg;
endmodule

// *** rtl/serial_port0_control_status.sv ***
// control and status logic of serial port 0 with an AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module serial_port0_control_status
  import serial0_pkg::*;
(
  input wire logic ref_clk, // system clock, 50 MHz
  input wire logic rst, // async reset, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic link_clk, // serial clock as seen on the line
  input wire logic scl_in, // clock line level
  input wire logic sda_in, // data line level
  output logic scl_out, // clock line drive value
  output logic scl_oe, // clock line drive enable
  output logic sda_out, // data line drive value
  output logic sda_oe, // data line drive enable
  output logic sio_event // one-cycle serial event pulse
);

  // ----------------------------------------------------------------
  // line synchronisers and link sampler
  // ----------------------------------------------------------------
  logic scl_s, sda_s, link_bit, link_bit_s;

  sync3 #(.WIDTH(2)) u_line_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  link_sampler u_sampler (
    .link_clk(link_clk),
    .rst(rst),
    .sda_in(sda_in),
    .bit_level(link_bit)
  );

  sync3 #(.WIDTH(1)) u_bit_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(link_bit),
    .q(link_bit_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] mode_reg, mode_next;
  logic [3:0] wait_reg, wait_next;
  logic [1:0] evt_sel_reg, evt_sel_next;
  logic [1:0] clk_sel_reg, clk_sel_next;
  logic ack_seen_reg, ack_seen_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_idx_reg, wr_idx_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic go_reg, go_next;

  logic scl_d_reg, sda_d_reg;
  logic [3:0] cnt_reg, cnt_next;
  logic count8_flag_reg, count8_flag_next;
  logic count9_flag_reg, count9_flag_next;
  logic clock_window_flag_reg, clock_window_flag_next;
  logic bus_busy_flag_reg, bus_busy_flag_next;
  logic first_byte_reg, first_byte_next;
  logic wait_active_reg, wait_active_next;
  logic event_reg, event_next;

  gen_state_type gen_reg, gen_next;
  logic [HALF_W-1:0] half_reg, half_next;
  logic [3:0] left_reg, left_next;
  logic scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next;

  logic bus_mode, two_wire, is_master, receiving;
  logic addr_ok, start_det, stop_det, scl_rise, scl_fall;
  logic [7:0] rd_idx;

  assign two_wire = ~mode_reg[MODE_LINES]; // RULE1
  assign bus_mode = mode_reg[MODE_PROTO]; // RULE1
  assign is_master = ~mode_reg[MODE_ROLE]; // RULE2
  assign receiving = ~mode_reg[MODE_DIR]; // RULE2

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_idx = haddr[ADDR_SHIFT +: 8];

  function automatic logic [3:0] read_word(input logic [7:0] idx,
                                            input logic [3:0] md,
                                            input logic [3:0] wt,
                                            input logic [3:0] st,
                                            input logic [1:0] ev,
                                            input logic [1:0] ck,
                                            input logic busy);
    read_word = 4'h0;
    if (idx == IDX_MODE) begin
      read_word = md;
    end else if (idx == IDX_WAIT) begin
      read_word = wt;
    end else if (idx == IDX_STATUS) begin
      read_word = st;
    end else if (idx == IDX_EVENT) begin
      read_word = {2'h0, ev};
    end else if (idx == IDX_CLKSEL) begin
      read_word = {2'h0, ck};
    end else if (idx == IDX_XFER) begin
      read_word = {3'h0, busy};
    end
  endfunction

  always_comb begin
    logic [3:0] wt_view;
    logic [3:0] st_view;
    wt_view = wait_reg;
    st_view = {count8_flag_reg, count9_flag_reg,
               clock_window_flag_reg, bus_busy_flag_reg};
    mode_next = mode_reg;
    wait_next = wait_reg;
    evt_sel_next = evt_sel_reg;
    clk_sel_next = clk_sel_reg;
    go_next = 1'b0;
    wr_pend_next = addr_ok & hwrite;
    wr_idx_next = addr_ok ? rd_idx : wr_idx_reg;
    hrdata_next = hrdata_reg;
    if (bus_mode) begin
      wt_view[WAIT_ACK] = ack_seen_reg; // RULE3
    end
    if (addr_ok & ~hwrite) begin
      hrdata_next = {28'h0, read_word(rd_idx, mode_reg, wt_view, st_view,
                                      evt_sel_reg, clk_sel_reg,
                                      gen_reg != GEN_IDLE)};
    end
    if (wr_pend_reg) begin
      if (wr_idx_reg == IDX_MODE) begin
        mode_next = hwdata[3:0];
      end
      if (wr_idx_reg == IDX_WAIT) begin
        wait_next = hwdata[3:0]; // RULE3 RULE8
      end
      if (wr_idx_reg == IDX_EVENT) begin
        evt_sel_next = hwdata[1:0]; // RULE9
      end
      if (wr_idx_reg == IDX_CLKSEL) begin
        clk_sel_next = hwdata[1:0]; // RULE10
      end
      if (wr_idx_reg == IDX_XFER) begin
        go_next = hwdata[XFER_GO];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      wait_reg <= WAIT_RESET;
      evt_sel_reg <= SEL_RESET;
      clk_sel_reg <= SEL_RESET;
      go_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      mode_reg <= mode_next;
      wait_reg <= wait_next;
      evt_sel_reg <= evt_sel_next;
      clk_sel_reg <= clk_sel_next;
      go_reg <= go_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // clock counter, flags, wait and event
  // ----------------------------------------------------------------
  always_comb begin
    logic wait_point;
    wait_point = 1'b0;
    cnt_next = cnt_reg;
    first_byte_next = first_byte_reg;
    ack_seen_next = ack_seen_reg;
    if (start_det & bus_mode) begin
      cnt_next = CNT_ZERO;
      first_byte_next = 1'b1;
    end else if (go_reg & ~bus_mode) begin
      cnt_next = CNT_ZERO;
    end else if (scl_rise) begin
      if ((cnt_reg == CNT_NINE) |
          (~bus_mode & (cnt_reg == CNT_EIGHT))) begin
        cnt_next = CNT_ONE;
      end else begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end
    // partner ack sits on the line at the ninth rise
    if (bus_mode & scl_s & (cnt_reg == CNT_NINE)) begin
      ack_seen_next = link_bit_s; // RULE3
    end
    if (scl_fall & (cnt_reg == CNT_NINE)) begin
      first_byte_next = 1'b0;
    end

    count8_flag_next = count8_flag_reg;
    count9_flag_next = count9_flag_reg;
    if (cnt_reg == CNT_EIGHT) begin
      count8_flag_next = 1'b1; // RULE5
    end else if ((cnt_reg == CNT_ZERO) | (cnt_reg == CNT_ONE)) begin
      count8_flag_next = 1'b0; // RULE5
    end
    if (cnt_reg == CNT_NINE) begin
      count9_flag_next = 1'b1; // RULE5
    end else if ((cnt_reg == CNT_ZERO) | (cnt_reg == CNT_ONE)) begin
      count9_flag_next = 1'b0; // RULE5
    end

    clock_window_flag_next = clock_window_flag_reg;
    if (~bus_mode) begin
      clock_window_flag_next = 1'b0;
    end else if (start_det) begin
      clock_window_flag_next = 1'b1; // RULE6
    end else if (cnt_reg == CNT_NINE) begin
      clock_window_flag_next = 1'b0; // RULE6
    end

    bus_busy_flag_next = bus_busy_flag_reg;
    if (~bus_mode) begin
      bus_busy_flag_next = 1'b0;
    end else if (start_det) begin
      bus_busy_flag_next = 1'b1; // RULE7
    end else if (stop_det) begin
      bus_busy_flag_next = 1'b0; // RULE7
    end

    unique case (wait_reg[1:0])
      WMODE_NONE: wait_point = 1'b0; // RULE8
      WMODE_DATA: wait_point = scl_fall & (cnt_reg == CNT_EIGHT);
      WMODE_ACK: wait_point = scl_fall & (cnt_reg == CNT_NINE);
      WMODE_ADDR: wait_point = scl_fall & (cnt_reg == CNT_NINE) &
                               first_byte_reg;
    endcase
    wait_active_next = wait_active_reg;
    if (wait_reg[WAIT_PERMIT]) begin
      wait_active_next = 1'b0; // RULE4
    end else if (wait_point) begin
      wait_active_next = 1'b1; // RULE4
    end

    event_next = 1'b0;
    unique case (evt_sel_reg)
      EVT_CLK7: event_next = scl_rise & (cnt_reg == CNT_SEVEN - 4'h1);
      EVT_CLK8: event_next = scl_rise & (cnt_reg == CNT_SEVEN); // RULE9
      EVT_START7: event_next = scl_rise & first_byte_reg &
                               (cnt_reg == CNT_SEVEN - 4'h1);
      EVT_STOP: event_next = stop_det & bus_mode; // RULE9
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      cnt_reg <= CNT_ZERO;
      first_byte_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      count8_flag_reg <= 1'b0;
      count9_flag_reg <= 1'b0;
      clock_window_flag_reg <= 1'b0;
      bus_busy_flag_reg <= 1'b0;
      wait_active_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      cnt_reg <= cnt_next;
      first_byte_reg <= first_byte_next;
      ack_seen_reg <= ack_seen_next;
      count8_flag_reg <= count8_flag_next;
      count9_flag_reg <= count9_flag_next;
      clock_window_flag_reg <= clock_window_flag_next;
      bus_busy_flag_reg <= bus_busy_flag_next;
      wait_active_reg <= wait_active_next;
      event_reg <= event_next;
    end
  end

  // ----------------------------------------------------------------
  // master clock generator and line drive
  // ----------------------------------------------------------------
  always_comb begin
    gen_next = gen_reg;
    half_next = half_reg;
    left_next = left_reg;
    unique case (gen_reg)
      GEN_IDLE: begin
        if (go_reg & is_master) begin // RULE2
          gen_next = GEN_LOW;
          half_next = half_cycles(clk_sel_reg); // RULE10
          left_next = bus_mode ? CNT_NINE : CNT_EIGHT;
        end
      end
      GEN_LOW: begin
        if (half_reg > HALF_W'(1)) begin
          half_next = half_reg - HALF_W'(1);
        end else if (~wait_active_reg) begin // RULE4
          gen_next = GEN_HIGH;
          half_next = half_cycles(clk_sel_reg); // RULE10
        end
      end
      GEN_HIGH: begin
        if (half_reg > HALF_W'(1)) begin
          half_next = half_reg - HALF_W'(1);
        end else if (left_reg == CNT_ONE) begin
          gen_next = GEN_IDLE;
          left_next = CNT_ZERO;
        end else begin
          gen_next = GEN_LOW;
          half_next = half_cycles(clk_sel_reg);
          left_next = left_reg - CNT_ONE;
        end
      end
      default: gen_next = GEN_IDLE;
    endcase
    // slave holds the clock low while waiting
    scl_oe_next = (gen_next == GEN_LOW) | wait_active_next; // RULE4
    // ack driven low only in two-wire bus receive
    sda_oe_next = bus_mode & two_wire & receiving &
                  ~wait_reg[WAIT_ACK] & (cnt_next == CNT_EIGHT) &
                  ~scl_s; // RULE1 RULE3
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gen_reg <= GEN_IDLE;
      half_reg <= '0;
      left_reg <= CNT_ZERO;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      gen_reg <= gen_next;
      half_reg <= half_next;
      left_reg <= left_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // open-drain lines: drive value is always low
  logic low_reg;
  logic ready_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      low_reg <= 1'b0;
      ready_reg <= 1'b1;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = low_reg;
  assign scl_out = low_reg;
  assign sda_out = low_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign sio_event = event_reg;
endmodule

// *** verification/serial0_partner.sv ***
// remote bus controller model at the far side of serial port 0
`timescale 1ns/1ps
module serial0_partner (
  output logic scl_drv, // clock drive, 1 releases
  output logic sda_drv, // data drive, 1 releases
  input wire logic scl_line, // resolved clock line
  input wire logic sda_line // resolved data line
);
  logic ack_seen;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    ack_seen = 1'b1;
  end
  // ----------------------------------------------------------------
  // frame pieces, clock still between frames
  // ----------------------------------------------------------------
  task automatic start_cond();
    #250;
    sda_drv = 1'b0; // falls with clock high
    #250;
    scl_drv = 1'b0;
  endtask
  task automatic clock_bit(input logic b);
    sda_drv = b;
    #62.5;
    scl_drv = 1'b1;
    wait (scl_line === 1'b1); // slave may stretch the clock
    ack_seen = sda_line;
    #62.5;
    scl_drv = 1'b0;
  endtask
  task automatic stop_cond();
    sda_drv = 1'b0;
    #62.5;
    scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #62.5;
    sda_drv = 1'b1; // rises with clock high
    #250;
  endtask
endmodule

// *** verification/serial0_asserts.sv ***
// port checker for the serial port 0 control/status block
`timescale 1ns/1ps
module serial0_asserts
  import serial0_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // ready
  input wire logic [31:0] hwdata, // write data
  input wire logic [31:0] hrdata, // read data
  input wire logic scl_out, // clock value
  input wire logic scl_oe, // clock enable
  input wire logic sda_out, // data value
  input wire logic sda_oe, // data enable
  input wire logic sio_event // event pulse
);
  logic ap_reg, ap_next, wr_reg, wr_next, rd_st, hold_off;
  logic [7:0] idx_reg, idx_next;
  logic [3:0] mode_reg, mode_next, wt_reg, wt_next;
  logic [1:0] ck_reg, ck_next;
  logic [9:0] lo_reg, lo_next;
  int khz;
  // ----------------------------------------------------------------
  // register shadow
  // ----------------------------------------------------------------
  always_comb begin
    ap_next = hsel & htrans[1] & hready;
    wr_next = hwrite;
    idx_next = haddr[9:2];
    mode_next = mode_reg;
    wt_next = wt_reg;
    ck_next = ck_reg;
    if (ap_reg && wr_reg && idx_reg == IDX_MODE)
      mode_next = hwdata[3:0];
    if (ap_reg && wr_reg && idx_reg == IDX_WAIT)
      wt_next = hwdata[3:0];
    if (ap_reg && wr_reg && idx_reg == IDX_CLKSEL)
      ck_next = hwdata[1:0];
    lo_next = scl_oe ? lo_reg + 10'h1 : 10'h0;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_reg <= 1'b0;
      wr_reg <= 1'b0;
      idx_reg <= 8'h0;
      mode_reg <= 4'h0;
      wt_reg <= 4'h0;
      ck_reg <= 2'h0;
      lo_reg <= 10'h0;
    end else begin
      ap_reg <= ap_next;
      wr_reg <= wr_next;
      idx_reg <= idx_next;
      mode_reg <= mode_next;
      wt_reg <= wt_next;
      ck_reg <= ck_next;
      lo_reg <= lo_next;
    end
  end
  assign rd_st = ap_reg & ~wr_reg & (idx_reg == IDX_STATUS);
  assign hold_off = mode_reg[MODE_ROLE]
                    & (wt_reg[WAIT_PERMIT] | (wt_reg[1:0] == WMODE_NONE));
  assign khz = ck_reg == 2'h0 ? RATE0_KHZ : ck_reg == 2'h1 ? RATE1_KHZ
             : ck_reg == 2'h2 ? RATE2_KHZ : RATE3_KHZ;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  busy_serial_a: assert property (
    rd_st && !mode_reg[MODE_PROTO] |-> hrdata[1:0] == 2'h0)
    else $error("bus flags set in serial mode");
  count_order_a: assert property (rd_st && hrdata[2] |-> hrdata[3])
    else $error("count9 without count8");
  window_busy_a: assert property (rd_st && hrdata[1] |-> hrdata[0])
    else $error("clock window without bus busy");
  ack_drive_a: assert property (
    sda_oe && mode_reg[MODE_PROTO] && !mode_reg[MODE_DIR]
    |-> !wt_reg[WAIT_ACK]) else $error("ack driven with ack bit 1");
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  no_hold_a: assert property (
    hold_off && $past(hold_off) && $past(hold_off, 3) |-> !scl_oe)
    else $error("clock held without wait");
  event_pulse_a: assert property (sio_event |=> !sio_event)
    else $error("event longer than one cycle");
  low_half_a: assert property (
    $fell(scl_oe) && !mode_reg[MODE_ROLE] && wt_reg[WAIT_PERMIT]
    |-> lo_reg == 10'(REF_CLK_HZ / (2000 * khz)))
    else $error("bad low half");
  cover property (rd_st && hrdata[1]);
  cover property ($fell(scl_oe) && !mode_reg[MODE_ROLE]);
  cover property (sio_event);
endmodule
bind serial_port0_control_status serial0_asserts u_chk (.*);

// *** verification/test_serial_port0_control_status.sv ***
// self-checking bench for the serial port 0 control/status block
`timescale 1ns/1ps
module test_serial_port0_control_status;
  import serial0_pkg::*;
  localparam logic [31:0] A_MODE = 32'h20, A_WAIT = 32'h60, A_STAT = 32'ha0,
    A_EVT = 32'he0, A_CK = 32'he4, A_XFER = 32'he8;
  logic ref_clk, rst, hsel, hwrite, hresp, hreadyout, oe_q;
  logic scl_out, scl_oe, sda_out, sda_oe, sio_event, scl_drv, sda_drv;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int fail_count, check_count, ev_count, oe_rises, cycles;
  wire hready = hreadyout;
  wire scl_line = scl_drv & ~scl_oe; // open drain, pulled up
  wire sda_line = sda_drv & ~sda_oe;
  serial_port0_control_status dut (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .link_clk(scl_line),
    .scl_in(scl_line), .sda_in(sda_line), .scl_out, .scl_oe, .sda_out,
    .sda_oe, .sio_event
  );
  serial0_partner peer (.scl_drv, .sda_drv, .scl_line, .sda_line);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (sio_event === 1'b1)
      ev_count++;
    if (scl_oe === 1'b1 && !oe_q)
      oe_rises++;
    oe_q = (scl_oe === 1'b1);
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // bus and compare
  // ----------------------------------------------------------------
  task automatic check(input string s, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    q = hrdata;
    check("resp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rchk(input string s, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0, rd);
    check(s, rd, e);
  endtask
  task automatic send(input logic [8:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
      peer.clock_bit(d[i]);
    repeat (12) @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] a [5] = '{A_MODE, A_WAIT, A_STAT, A_EVT, A_CK};
    logic [31:0] m [5] = '{32'hf, 32'hf, 32'h0, 32'h3, 32'h3};
    for (int i = 0; i < 5; i++)
      rchk("reset value", a[i], 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 32'hffff_ffff);
      rchk("readback", a[i], m[i]);
      wr(a[i], 32'h0);
    end
    wr(32'h4, 32'hf);
    rchk("unmapped", 32'h4, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_frames();
    wr(A_MODE, 32'h6);
    for (int e = 0; e < 4; e++) begin
      wr(A_WAIT, {28'h0, e[0], 3'h0});
      wr(A_EVT, 32'(e));
      ev_count = 0;
      peer.start_cond();
      send(9'h0, 0);
      rchk("after start", A_STAT, 32'h3);
      send(9'h0b6, 8);
      rchk("after eight", A_STAT, 32'hb);
      send(9'h1, 1);
      rchk("after nine", A_STAT, 32'hd);
      rchk("ack read", A_WAIT, {28'h0, e[0], 3'h0});
      check("ack seen", {31'h0, peer.ack_seen}, {31'h0, e[0]});
      peer.stop_cond();
      send(9'h0, 0);
      rchk("after stop", A_STAT, 32'h0);
      check("events", 32'(ev_count), 32'h1);
    end
    $display("test_frames done");
  endtask
  task automatic test_serial();
    wr(A_MODE, 32'h2);
    peer.start_cond();
    send(9'h0a5, 8);
    rchk("serial flags", A_STAT, 32'h0);
    peer.stop_cond();
    $display("test_serial done");
  endtask
  task automatic test_wait();
    logic [1:0] wm [3] = '{WMODE_DATA, WMODE_ACK, WMODE_ADDR};
    wr(A_MODE, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wr(A_WAIT, {30'h0, wm[i]});
      fork
        begin
          peer.start_cond();
          send(9'h1a5, 9);
          peer.stop_cond();
        end
        begin
          while (scl_oe !== 1'b1) @(posedge ref_clk);
          repeat (40) @(posedge ref_clk);
          check("held", {31'h0, scl_oe}, 32'h1);
          wr(A_WAIT, {29'h0, 1'b1, wm[i]});
        end
      join
    end
    $display("test_wait done");
  endtask
  task automatic test_master();
    int kz [4] = '{RATE0_KHZ, RATE1_KHZ, RATE2_KHZ, RATE3_KHZ};
    int n;
    wr(A_MODE, 32'h0);
    wr(A_WAIT, 32'h4);
    for (int r = 0; r < 4; r++) begin
      wr(A_CK, 32'(r));
      oe_rises = 0;
      wr(A_XFER, 32'h1);
      while (scl_oe !== 1'b1) @(posedge ref_clk);
      n = 0;
      while (scl_oe === 1'b1) begin
        @(posedge ref_clk);
        n++;
      end
      check("low half", 32'(n), 32'(REF_CLK_HZ / (2000 * kz[r])));
      do bus(1'b0, A_XFER, 32'h0, rd); while (rd[0] !== 1'b0);
      check("clocks", 32'(oe_rises), 32'h8);
      rchk("count8 serial", A_STAT, 32'h8);
    end
    $display("test_master done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    oe_q = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    test_regs();
    test_frames();
    test_serial();
    test_wait();
    test_master();
    print_verdict();
  end
endmodule
